// ### dv/msps_plc_model.sv
`timescale 1ns/10ps
// controller stand-in: answers a raised m code lag cycles after it is first seen
module msps_plc_model (
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic       mcode_on,
	input  wire logic [7:0] lag,
	output logic            mcode_off_cmd
);
	logic [7:0] cnt_q;
	// off is held until on falls, as a slow scan would
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_q         <= 8'h00;
			mcode_off_cmd <= 1'b0;
		end else if (!mcode_on) begin
			cnt_q         <= 8'h00;
			mcode_off_cmd <= 1'b0;
		end else if (cnt_q >= lag) begin
			mcode_off_cmd <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
endmodule : msps_plc_model

// ### dv/test_multistep_path_sequencer.sv
`timescale 1ns/10ps
module test_multistep_path_sequencer;
	import msps_pkg::*;
	logic mclk, rstn, seq_start, mcode_step_hold_flag, instr_valid, instr_by_word;
	logic instr_has_code, opd_x_given, opd_y_given, opd_i_given, opd_j_given, opd_r_given;
	logic opd_f_given, opd_k_given, opd_m_given, opd_m_indirect, step_ready, mot_at_target;
	logic mot_decel, mcode_off_cmd, seq_busy, seq_done, seq_err, instr_ready, step_valid;
	logic step_blend, mcode_on, drain;
	logic [WORD_W-1:0] instr_word;
	logic [CODE_W-1:0] instr_code;
	logic [POS_W-1:0]  opd_x, opd_y, opd_i, opd_j, opd_r, mot_pos_x, mot_pos_y;
	logic [POS_W-1:0]  ramp_need_pulses, step_x, step_y, pos;
	logic [POS_W-1:0]  step_ctr_i, step_ctr_j, step_radius;
	logic [SPD_W-1:0]  opd_f, step_speed, last_f;
	logic [K_W-1:0]    opd_k;
	logic [M_W-1:0]    opd_m, mcode_num;
	logic [7:0]        lag;
	msps_err_t         seq_err_code;
	msps_op_t          step_op;
	int                errors, n_tests, outst, dones, seed, last_n, d0;
	logic [CODE_W-1:0] ecode [4] = '{CODE_CW, CODE_TIM, 8'h00, CODE_LIN};
	msps_err_t         eexp [4] = '{ERR_OMITTED, ERR_OMITTED, ERR_UNKNOWN, ERR_MCODE_INDIRECT};

	msps_multistep_sequencer #(.TWO_AXIS(1'b1), .TIMER_UNIT_CYCLES(4))
	u_msps_multistep_sequencer (
		.mclk, .rstn, .seq_start, .mcode_step_hold_flag, .seq_busy, .seq_done, .seq_err,
		.seq_err_code, .instr_valid, .instr_ready, .instr_by_word, .instr_word,
		.instr_has_code, .instr_code, .opd_x_given, .opd_x, .opd_y_given, .opd_y,
		.opd_i_given, .opd_i, .opd_j_given, .opd_j, .opd_r_given, .opd_r, .opd_f_given,
		.opd_f, .opd_k_given, .opd_k, .opd_m_given, .opd_m, .opd_m_indirect, .step_valid,
		.step_ready, .step_op, .step_blend, .step_x, .step_y, .step_speed, .step_ctr_i,
		.step_ctr_j, .step_radius, .mot_pos_x, .mot_pos_y, .mot_at_target, .mot_decel,
		.ramp_need_pulses, .mcode_off_cmd, .mcode_on, .mcode_num);
	msps_plc_model u_msps_plc_model (.mclk, .rstn, .mcode_on, .lag, .mcode_off_cmd);

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// engine keeps one step in flight so the chain counts as running
	always @(posedge mclk) begin
		if (step_valid === 1'b1 && step_ready === 1'b1) outst++;
		if (mot_at_target === 1'b1) outst--;
		if (seq_done === 1'b1) dones++;
	end
	always @(negedge mclk) begin
		mot_at_target <= outst == 2 || (drain && outst > 0);
		step_ready    <= $random(seed);
	end

	// a running linear step may join only if not short and not under the ramp
	function automatic logic exp_join(input int trav, input int spd, input int need);
		return trav * MS_PER_S > spd * STEP_MIN_MS && trav >= need;
	endfunction : exp_join

	task automatic final_report;
		$display("errors %0d comparisons %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask : chk

	task automatic tmo(input int n);
		if (n >= 400) begin
			errors++;
			$display("BAD %0t wait ran out", $time);
			final_report();
		end
	endtask : tmo

	task automatic clr(input logic w);
		{instr_by_word, instr_word, instr_has_code, instr_code} = {w, WORD_LIN, !w, CODE_LIN};
		{opd_x_given, opd_f_given, opd_k_given, opd_m_given, opd_m_indirect} = 5'h00;
		{opd_i_given, opd_j_given, opd_r_given} = 3'h0;
		{opd_x, opd_y, opd_i} = {$random(seed), $random(seed), $random(seed)};
		{opd_j, opd_r} = {$random(seed), $random(seed)};
		opd_f = SPD_W'($random(seed));
		opd_k = K_W'($random(seed));
		opd_m = 7'h0A;
	endtask : clr

	// request held from a falling edge until ready was seen before a rising one
	task automatic go;
		int n;
		n = 0;
		instr_valid = 1'b1;
		while (instr_ready !== 1'b1 && n < 400) begin
			@(negedge mclk);
			n++;
		end
		tmo(n);
		@(negedge mclk);
		instr_valid = 1'b0;
		n = 0;
		while (instr_ready !== 1'b1 && seq_busy === 1'b1 && n < 400) begin
			@(negedge mclk);
			n++;
		end
		tmo(n);
		last_n = n;
		@(negedge mclk);
	endtask : go

	task automatic settle;
		int n;
		n = 0;
		drain = 1'b1;
		while ((outst != 0 || mcode_on !== 1'b0) && n < 400) begin
			@(negedge mclk);
			n++;
		end
		tmo(n);
		drain = 1'b0;
	endtask : settle

	task automatic start;
		seq_start = 1'b1;
		@(negedge mclk);
		seq_start = 1'b0;
		@(negedge mclk);
	endtask : start

	initial begin
		seed = 32'h02B1;
		{errors, n_tests, outst, dones} = 128'h0;
		{rstn, seq_start, mcode_step_hold_flag, instr_valid, step_ready, mot_at_target} = 6'h00;
		{mot_decel, drain, opd_y_given, opd_i_given, opd_j_given, opd_r_given} = 6'h00;
		{mot_pos_x, mot_pos_y, ramp_need_pulses, lag, last_f} = {64'h0, 32'd10, 8'd4, 18'h0};
		clr(1'b0);
		repeat (4) @(negedge mclk);
		chk(mcode_on, 0, "reset on");
		rstn = 1'b1;
		start();
		clr(1'b0);
		instr_code = CODE_INCR;
		go();
		for (int s = 0; s < 8; s++) begin
			clr(s[0]);
			{opd_x_given, opd_f_given} = {1'b1, s == 0 || ($random(seed) & 1) == 0};
			opd_x = 32'd2000 + {20'h0, 12'($random(seed))};
			if (opd_f_given) begin
				opd_f = 18'd500 + {8'h00, 10'($random(seed))};
				last_f = opd_f;
			end
			go();
			chk(step_speed, last_f, "speed");
			chk(step_blend, s > 0, "chain");
		end
		for (int s = 0; s < 3; s++) begin
			clr(1'b0);
			{opd_x_given, opd_f_given, opd_f} = {2'b11, 18'd1000};
			opd_x = s == 0 ? 32'd20 : 32'd3000;
			ramp_need_pulses = s == 1 ? 32'd5000 : 32'd10;
			go();
			chk(step_blend, exp_join(opd_x, 1000, ramp_need_pulses), "short or ramp");
		end
		clr(1'b1);
		instr_word = WORD_ATRV;
		go();
		clr(1'b0);
		{opd_x_given, opd_x, pos} = {1'b1, 32'd50000, 32'd50000};
		go();
		chk(step_blend, 0, "mode change");
		chk(step_x, pos, "abs target");
		settle();
		mot_pos_x = pos;
		clr(1'b0);
		go();
		chk(step_x, pos, "x kept");
		chk(step_y, 0, "y kept");
		chk(step_speed, 18'd1000, "speed kept");
		chk(mcode_on, 0, "no m code");
		for (int r = 0; r < 4; r++) begin
			settle();
			{mcode_step_hold_flag, mot_decel, lag} = {r > 0, r == 3, r < 2 ? 8'd40 : 8'd3};
			mot_pos_x = pos;
			clr(1'b0);
			{opd_x_given, opd_x, opd_m_given, opd_m} = {1'b1, pos + 32'd3000, 1'b1, 7'h0B};
			go();
			chk(mcode_num, 7'h0B, "m number");
			clr(1'b0);
			{opd_x_given, opd_x} = {1'b1, pos + 32'd6000};
			go();
			pos = pos + 32'd6000;
			if (r < 2) chk(mcode_on, r == 0, "on at next step");
			if (r != 1) chk(step_blend, r != 3, "hold blend");
		end
		settle();
		clr(1'b0);
		{instr_code, opd_k_given, opd_k} = {CODE_TIM, 1'b1, 16'h0002};
		go();
		chk(last_n >= 8 && last_n <= 12, 1, "dwell");
		clr(1'b0);
		{instr_code, opd_r_given, opd_i_given, opd_j_given} = {CODE_CW, 3'b101};
		go();
		chk(step_op, OP_CW, "arc op");
		chk(step_blend, 0, "arc stops");
		chk(step_ctr_i, 0, "centre i");
		chk(step_ctr_j, opd_j, "centre j");
		chk(step_radius, opd_r, "radius");
		settle();
		clr(1'b0);
		{instr_has_code, opd_m_given, opd_m} = {1'b0, 1'b1, M_END};
		d0 = dones;
		go();
		repeat (2) @(negedge mclk);
		chk(dones, d0 + 1, "end");
		chk(seq_busy, 0, "idle at end");
		for (int r = 0; r < 4; r++) begin
			start();
			clr(r == 2);
			{instr_code, instr_word} = {ecode[r], 24'h5A5A5A};
			{opd_m_given, opd_m_indirect} = {r == 3, r == 3};
			go();
			chk(seq_err, 1, "err flag");
			chk(seq_err_code, eexp[r], "err code");
		end
		start();
		chk(seq_err, 0, "err cleared");
		final_report();
	end
endmodule : test_multistep_path_sequencer

// ### src/msps_multistep_sequencer.sv
`timescale 1ns/10ps
// Summary of operation
// RULE1: consecutive linear steps on one axis run as one move without stopping
// RULE2: absolute or incremental travel allowed; a change of method forces a stop
// RULE3: stop at a boundary when the step is shorter than the speed ramp needs
// RULE4: stop at a step whose travel time is fifty milliseconds or less
// RULE5: no limit on how many steps are chained
// RULE6: hold off: chain runs on despite pending m code; wait for off after chain
// RULE7: each m code raises the on signal and stores its number until off arrives; with hold off, a code on a step issued while on is still high is dropped
// RULE8: two axis variant allows one given axis; the other axis stays put
// RULE9: hold on with m code pending: do not advance to the next step speed
// RULE10: hold on, off before deceleration: switch straight to the next speed
// RULE11: hold on, off inside deceleration: finish at target, then start next
// RULE12: hold on, no off by step end: stop at target and wait for off
// RULE13: instruction accepted by word or by number, both treated alike
// RULE14: the program source gives operands in the fixed order of each instruction
// RULE15: an omitted axis travel keeps that axis at its present position
// RULE16: an omitted arc centre offset counts as zero
// RULE17: arc radius and timer constant cannot be omitted; timer unit is 10 ms
// RULE18: an omitted speed reuses the last speed given
// RULE19: m code operand optional, direct value only
// RULE20: off command sampled every clock and latched until the next decision
module msps_multistep_sequencer
	import msps_pkg::*;
#(
	parameter bit TWO_AXIS          = 1'b1,
	parameter int TIMER_UNIT_CYCLES = TIMER_UNIT_CYCLES_DEF
) (
	input  wire logic              mclk,
	input  wire logic              rstn,
	input  wire logic              seq_start,
	input  wire logic              mcode_step_hold_flag,
	output logic                   seq_busy,
	output logic                   seq_done,
	output logic                   seq_err,
	output msps_err_t              seq_err_code,
	input  wire logic              instr_valid,
	output logic                   instr_ready,
	input  wire logic              instr_by_word,
	input  wire logic [WORD_W-1:0] instr_word,
	input  wire logic              instr_has_code,
	input  wire logic [CODE_W-1:0] instr_code,
	input  wire logic              opd_x_given,
	input  wire logic [POS_W-1:0]  opd_x,
	input  wire logic              opd_y_given,
	input  wire logic [POS_W-1:0]  opd_y,
	input  wire logic              opd_i_given,
	input  wire logic [POS_W-1:0]  opd_i,
	input  wire logic              opd_j_given,
	input  wire logic [POS_W-1:0]  opd_j,
	input  wire logic              opd_r_given,
	input  wire logic [POS_W-1:0]  opd_r,
	input  wire logic              opd_f_given,
	input  wire logic [SPD_W-1:0]  opd_f,
	input  wire logic              opd_k_given,
	input  wire logic [K_W-1:0]    opd_k,
	input  wire logic              opd_m_given,
	input  wire logic [M_W-1:0]    opd_m,
	input  wire logic              opd_m_indirect,
	output logic                   step_valid,
	input  wire logic              step_ready,
	output msps_op_t               step_op,
	output logic                   step_blend,
	output logic [POS_W-1:0]       step_x,
	output logic [POS_W-1:0]       step_y,
	output logic [SPD_W-1:0]       step_speed,
	output logic [POS_W-1:0]       step_ctr_i,
	output logic [POS_W-1:0]       step_ctr_j,
	output logic [POS_W-1:0]       step_radius,
	input  wire logic [POS_W-1:0]  mot_pos_x,
	input  wire logic [POS_W-1:0]  mot_pos_y,
	input  wire logic              mot_at_target,
	input  wire logic              mot_decel,
	input  wire logic [POS_W-1:0]  ramp_need_pulses,
	input  wire logic              mcode_off_cmd,
	output logic                   mcode_on,
	output logic [M_W-1:0]         mcode_num
);

	localparam int TW = $clog2(TIMER_UNIT_CYCLES);

	if (TIMER_UNIT_CYCLES < 2) begin : g_chk_timer
		$error("TIMER_UNIT_CYCLES must be at least 2");
	end

	typedef enum logic [5:0] {
		S_IDLE   = 6'b000001,
		S_FETCH  = 6'b000010,
		S_DECIDE = 6'b000100,
		S_ISSUE  = 6'b001000,
		S_DRAIN  = 6'b010000,
		S_DWELL  = 6'b100000
	} msps_state_t;

	msps_resolve_if rif ();

	msps_state_t      st_q;
	msps_res_t        nxt_q;
	logic             blend_q;
	logic [1:0]       out_cnt_q;
	logic [POS_W-1:0] last_x_q;
	logic [POS_W-1:0] last_y_q;
	logic             incr_q;
	logic             step_mode_q;
	logic             cur_lin_q;
	logic             cur_with_m_q;
	logic             moff_m_q;
	logic             moff_s_q;
	logic             mcode_on_q;
	logic [M_W-1:0]   mcode_num_q;
	logic             done_q;
	logic             err_q;
	msps_err_t        err_code_q;
	logic [K_W-1:0]   unit_cnt_q;
	logic [TW-1:0]    tick_cnt_q;

	logic             take;
	logic             issue_take;
	logic             running_c;
	logic             drain_go;
	logic [POS_W-1:0] trav_c;
	logic             short_c;
	logic             ramp_c;
	logic             decel_hold_c;
	logic             wait_c;
	logic             blend_c;
	logic             m_emit;
	logic [M_W-1:0]   m_emit_num;

	function automatic logic [POS_W-1:0] absdiff(input logic [POS_W-1:0] a,
			input logic [POS_W-1:0] b);
		logic [POS_W-1:0] d;
		d = a - b;
		return d[POS_W-1] ? POS_W'(-d) : d;
	endfunction : absdiff

	// travel/speed <= 50 ms, rearranged to avoid a divider
	function automatic logic step_is_short(input logic [POS_W-1:0] trav,
			input logic [SPD_W-1:0] spd);
		logic [47:0] lhs;
		logic [47:0] rhs;
		lhs = 48'(trav) * 48'(MS_PER_S);
		rhs = 48'(spd) * 48'(STEP_MIN_MS);
		return lhs <= rhs;
	endfunction : step_is_short

	// operands packed in their fixed order
	assign rif.raw = '{by_word: instr_by_word, word: instr_word, // RULE14
		has_code: instr_has_code, code: instr_code,
		x_given: opd_x_given, x: opd_x,
		y_given: TWO_AXIS & opd_y_given, y: opd_y, // RULE8
		i_given: opd_i_given, i: opd_i, j_given: opd_j_given, j: opd_j,
		r_given: opd_r_given, r: opd_r, f_given: opd_f_given, f: opd_f,
		k_given: opd_k_given, k: opd_k, m_given: opd_m_given, m: opd_m,
		m_indirect: opd_m_indirect};
	assign rif.base_x    = last_x_q;
	assign rif.base_y    = last_y_q;
	assign rif.incr_mode = incr_q;
	assign rif.take      = take;

	msps_operand_resolver u_resolver (
		.mclk (mclk),
		.rstn (rstn),
		.rif  (rif.resolver)
	);

	assign instr_ready = (st_q == S_FETCH);
	assign take        = instr_valid && instr_ready;
	assign step_valid  = (st_q == S_ISSUE);
	assign issue_take  = step_valid && step_ready;
	assign seq_busy    = (st_q != S_IDLE);
	assign running_c   = (out_cnt_q != 2'h0);
	assign drain_go    = !running_c && !mcode_on_q;

	assign step_op     = nxt_q.op;
	assign step_blend  = blend_q;
	assign step_x      = nxt_q.x;
	assign step_y      = nxt_q.y;
	assign step_speed  = nxt_q.speed;
	assign step_ctr_i  = nxt_q.i;
	assign step_ctr_j  = nxt_q.j;
	assign step_radius = nxt_q.r;
	assign mcode_on    = mcode_on_q;
	assign mcode_num   = mcode_num_q;
	assign seq_done    = done_q;
	assign seq_err     = err_q;
	assign seq_err_code = err_code_q;

	// boundary decision for the next linear step
	always_comb begin
		trav_c = absdiff(nxt_q.x, last_x_q);
		if (absdiff(nxt_q.y, last_y_q) > trav_c) begin
			trav_c = absdiff(nxt_q.y, last_y_q);
		end
		short_c      = step_is_short(trav_c, nxt_q.speed); // RULE4
		ramp_c       = trav_c < ramp_need_pulses; // RULE3
		decel_hold_c = mcode_step_hold_flag && cur_with_m_q && mot_decel; // RULE11
		// hold flag freezes the chain on a pending m code; otherwise only a stop waits
		wait_c = (mcode_on_q && (mcode_step_hold_flag || !running_c)) || // RULE9 RULE12 RULE6
			(out_cnt_q == OUT_MAX);
		// an off that came before deceleration lets the chain blend on
		blend_c = running_c && cur_lin_q && (incr_q == step_mode_q) && // RULE1 RULE2 RULE10
			!ramp_c && !short_c && !decel_hold_c;
	end

	always_comb begin
		m_emit     = 1'b0;
		m_emit_num = nxt_q.m;
		if (issue_take && nxt_q.m_valid && !mcode_on_q) begin
			// a new code cannot be taken while the previous one is still on
			m_emit = 1'b1; // RULE6
		end else if (st_q == S_DRAIN && drain_go && nxt_q.m_valid &&
				(nxt_q.op == OP_TIM || (nxt_q.op == OP_MONLY && nxt_q.m != M_END))) begin
			m_emit = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_q <= S_IDLE;
		end else begin
			unique case (st_q)
				S_IDLE: begin
					if (seq_start) begin
						st_q <= S_FETCH;
					end
				end
				S_FETCH: begin
					if (take) begin
						if (rif.res.err != ERR_NONE) begin
							st_q <= S_IDLE; // RULE17 RULE19
						end else if (rif.res.op == OP_LIN) begin
							st_q <= S_DECIDE;
						end else if (rif.res.op != OP_ABSOLUTE_TRAVEL_INSTR &&
								rif.res.op != OP_INCR) begin
							st_q <= S_DRAIN;
						end
					end
				end
				S_DECIDE: begin
					if (!wait_c) begin
						st_q <= S_ISSUE;
					end
				end
				S_ISSUE: begin
					if (step_ready) begin
						st_q <= S_FETCH;
					end
				end
				S_DRAIN: begin
					if (drain_go) begin
						unique case (nxt_q.op)
							OP_TIM:   st_q <= S_DWELL;
							OP_CW,
							OP_CCW:   st_q <= S_ISSUE;
							default:  st_q <= (nxt_q.m == M_END) ? S_IDLE : S_FETCH;
						endcase
					end
				end
				S_DWELL: begin
					if (unit_cnt_q == '0) begin
						st_q <= S_FETCH;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			nxt_q   <= '0;
			blend_q <= 1'b0;
		end else begin
			if (take) begin
				nxt_q <= rif.res;
			end
			if (st_q == S_DECIDE && !wait_c) begin
				blend_q <= blend_c;
			end else if (st_q == S_DRAIN) begin
				blend_q <= 1'b0;
			end
		end
	end

	// steps accepted by the engine but not yet at target; at most current plus one
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			out_cnt_q <= 2'h0;
		end else begin
			unique case ({issue_take, mot_at_target && running_c})
				2'b10:   out_cnt_q <= out_cnt_q + 2'h1; // RULE5
				2'b01:   out_cnt_q <= out_cnt_q - 2'h1;
				default: out_cnt_q <= out_cnt_q;
			endcase
		end
	end

	// base for incremental travel: last target while moving, live position at rest
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			last_x_q     <= '0;
			last_y_q     <= '0;
			step_mode_q  <= MODE_RST;
			cur_lin_q    <= 1'b0;
			cur_with_m_q <= 1'b0;
		end else if (issue_take) begin
			last_x_q     <= nxt_q.x;
			last_y_q     <= nxt_q.y;
			step_mode_q  <= incr_q;
			cur_lin_q    <= (nxt_q.op == OP_LIN);
			cur_with_m_q <= nxt_q.m_valid;
		end else if (!running_c && st_q != S_ISSUE && st_q != S_DECIDE) begin
			last_x_q <= mot_pos_x;
			last_y_q <= mot_pos_y;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			incr_q <= MODE_RST;
		end else if (take && rif.res.err == ERR_NONE) begin
			if (rif.res.op == OP_INCR) begin
				incr_q <= 1'b1; // RULE2
			end else if (rif.res.op == OP_ABSOLUTE_TRAVEL_INSTR) begin
				incr_q <= 1'b0; // RULE2
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			moff_m_q <= 1'b0;
			moff_s_q <= 1'b0;
		end else begin
			moff_m_q <= mcode_off_cmd; // RULE20
			moff_s_q <= moff_m_q;
		end
	end

	// the on flag itself latches an off pulse; a new code in the same cycle wins
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mcode_on_q  <= 1'b0;
			mcode_num_q <= '0;
		end else if (m_emit) begin
			mcode_on_q  <= 1'b1; // RULE7
			mcode_num_q <= m_emit_num; // RULE7
		end else if (moff_s_q) begin
			mcode_on_q  <= 1'b0; // RULE7 RULE20
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			unit_cnt_q <= '0;
			tick_cnt_q <= '0;
		end else if (st_q == S_DRAIN) begin
			unit_cnt_q <= nxt_q.k;
			tick_cnt_q <= '0;
		end else if (st_q == S_DWELL && unit_cnt_q != '0) begin
			if (tick_cnt_q == TW'(TIMER_UNIT_CYCLES - 1)) begin
				tick_cnt_q <= '0;
				unit_cnt_q <= unit_cnt_q - K_W'(1); // RULE17
			end else begin
				tick_cnt_q <= tick_cnt_q + TW'(1);
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			done_q     <= 1'b0;
			err_q      <= 1'b0;
			err_code_q <= ERR_NONE;
		end else begin
			done_q <= (st_q == S_DRAIN) && drain_go && nxt_q.op == OP_MONLY &&
				nxt_q.m == M_END;
			if (take && rif.res.err != ERR_NONE) begin
				err_q      <= 1'b1; // RULE17 RULE19
				err_code_q <= rif.res.err;
			end else if (seq_start && st_q == S_IDLE) begin
				err_q      <= 1'b0;
				err_code_q <= ERR_NONE;
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence s_issue_taken;
		step_valid && step_ready;
	endsequence

	sequence s_decide_go;
		st_q == S_DECIDE && !wait_c;
	endsequence

	a_mcode_on_keep: assert property (mcode_on && !moff_s_q |=> mcode_on) // RULE7
		else $error("m code on dropped without off command");
	a_mcode_off_clear: assert property (mcode_on && moff_s_q && !m_emit |=> !mcode_on) // RULE20
		else $error("latched off command did not clear m code on");
	a_issue_mcode_out: assert property (s_issue_taken ##0 (nxt_q.m_valid && !mcode_on_q) // RULE7
		|=> mcode_on && mcode_num == $past(nxt_q.m))
		else $error("m code of issued step not output");
	a_hold_no_advance: assert property (st_q == S_DECIDE && mcode_step_hold_flag && // RULE9
		mcode_on_q |=> st_q == S_DECIDE)
		else $error("step advanced while held m code pending");
	a_decel_no_blend: assert property (s_decide_go ##0 decel_hold_c // RULE11
		|=> step_valid && !step_blend)
		else $error("off in deceleration range still blended");
	a_mode_chg_stop: assert property (s_decide_go ##0 (incr_q != step_mode_q) // RULE2
		|=> !step_blend)
		else $error("drive method change did not stop");
	a_short_step_stop: assert property (s_decide_go ##0 short_c |=> !step_blend) // RULE4
		else $error("short step was blended");
	a_ramp_short_stop: assert property (s_decide_go ##0 ramp_c |=> !step_blend) // RULE3
		else $error("step shorter than ramp was blended");
	a_reject_error: assert property (take && rif.res.err != ERR_NONE // RULE17
		|=> seq_err && !seq_busy)
		else $error("bad instruction not rejected");

endmodule : msps_multistep_sequencer

// ### src/msps_operand_resolver.sv
`timescale 1ns/10ps
module msps_operand_resolver
	import msps_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rstn,
	msps_resolve_if.resolver rif
);

	logic [SPD_W-1:0] last_f_q;

	function automatic msps_op_t decode_op(input msps_raw_t r);
		msps_op_t op;
		op = OP_BAD;
		if (r.by_word) begin
			case (r.word)
				WORD_LIN:  op = OP_LIN;
				WORD_CW:   op = OP_CW;
				WORD_CCW:  op = OP_CCW;
				WORD_TIM:  op = OP_TIM;
				WORD_ATRV: op = OP_ABSOLUTE_TRAVEL_INSTR;
				WORD_INCR: op = OP_INCR;
				default:   op = OP_BAD;
			endcase
		end else if (r.has_code) begin
			case (r.code)
				CODE_LIN:  op = OP_LIN;
				CODE_CW:   op = OP_CW;
				CODE_CCW:  op = OP_CCW;
				CODE_TIM:  op = OP_TIM;
				CODE_ATRV: op = OP_ABSOLUTE_TRAVEL_INSTR;
				CODE_INCR: op = OP_INCR;
				default:   op = OP_BAD;
			endcase
		end else if (r.m_given) begin
			op = OP_MONLY;
		end
		return op;
	endfunction : decode_op

	// word and number decode to the same op, so the rest never sees the form
	always_comb begin
		rif.res.op = decode_op(rif.raw); // RULE13
		rif.res.err = ERR_NONE;
		if (rif.res.op == OP_BAD) begin
			rif.res.err = ERR_UNKNOWN;
		end else if (((rif.res.op == OP_CW || rif.res.op == OP_CCW) && !rif.raw.r_given) ||
				(rif.res.op == OP_TIM && !rif.raw.k_given)) begin
			rif.res.err = ERR_OMITTED; // RULE17
		end else if (rif.raw.m_given && rif.raw.m_indirect) begin
			rif.res.err = ERR_MCODE_INDIRECT; // RULE19
		end
		// omitted axis stays where it is
		if (!rif.raw.x_given) begin
			rif.res.x = rif.base_x; // RULE15
		end else begin
			rif.res.x = rif.incr_mode ? rif.base_x + rif.raw.x : rif.raw.x;
		end
		if (!rif.raw.y_given) begin
			rif.res.y = rif.base_y; // RULE15
		end else begin
			rif.res.y = rif.incr_mode ? rif.base_y + rif.raw.y : rif.raw.y;
		end
		rif.res.i = rif.raw.i_given ? rif.raw.i : '0; // RULE16
		rif.res.j = rif.raw.j_given ? rif.raw.j : '0; // RULE16
		rif.res.r = rif.raw.r;
		rif.res.speed = rif.raw.f_given ? rif.raw.f : last_f_q; // RULE18
		rif.res.k = rif.raw.k;
		rif.res.m_valid = rif.raw.m_given; // RULE19
		rif.res.m = rif.raw.m;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			last_f_q <= SPEED_RST;
		end else if (rif.take && rif.raw.f_given) begin
			last_f_q <= rif.raw.f; // RULE18
		end
	end

endmodule : msps_operand_resolver

// ### src/msps_pkg.sv
package msps_pkg;

	localparam int POS_W  = 32;
	localparam int SPD_W  = 18;
	localparam int K_W    = 16;
	localparam int M_W    = 7;
	localparam int CODE_W = 8;
	localparam int WORD_W = 24;

	// instruction numbers
	localparam logic [CODE_W-1:0] CODE_LIN  = 8'h01;
	localparam logic [CODE_W-1:0] CODE_CW   = 8'h02;
	localparam logic [CODE_W-1:0] CODE_CCW  = 8'h03;
	localparam logic [CODE_W-1:0] CODE_TIM  = 8'h04;
	localparam logic [CODE_W-1:0] CODE_ATRV = 8'h5A;
	localparam logic [CODE_W-1:0] CODE_INCR = 8'h5B;

	// instruction words, three ASCII characters, space padded
	localparam logic [WORD_W-1:0] WORD_LIN  = 24'h4C494E;
	localparam logic [WORD_W-1:0] WORD_CW   = 24'h435720;
	localparam logic [WORD_W-1:0] WORD_CCW  = 24'h434357;
	localparam logic [WORD_W-1:0] WORD_TIM  = 24'h54494D;
	localparam logic [WORD_W-1:0] WORD_ATRV = 24'h414253;
	localparam logic [WORD_W-1:0] WORD_INCR = 24'h494E43;

	localparam logic [M_W-1:0]   M_END      = 7'h02;
	localparam logic [SPD_W-1:0] SPEED_RST  = 18'h00000;
	localparam logic             MODE_RST   = 1'b0;

	// timing
	localparam int CLK_HZ        = 10_000_000;
	localparam int MS_PER_S      = 1000;
	localparam int STEP_MIN_MS   = 50;
	localparam int TIMER_UNIT_MS = 10;
	localparam int TIMER_UNIT_CYCLES_DEF = TIMER_UNIT_MS * (CLK_HZ / MS_PER_S);

	localparam logic [1:0] OUT_MAX = 2'h2;

	typedef enum logic [2:0] {
		OP_LIN                   = 3'h0,
		OP_CW                    = 3'h1,
		OP_CCW                   = 3'h2,
		OP_TIM                   = 3'h3,
		OP_ABSOLUTE_TRAVEL_INSTR = 3'h4,
		OP_INCR                  = 3'h5,
		OP_MONLY                 = 3'h6,
		OP_BAD                   = 3'h7
	} msps_op_t;

	typedef enum logic [1:0] {
		ERR_NONE           = 2'h0,
		ERR_UNKNOWN        = 2'h1,
		ERR_OMITTED        = 2'h2,
		ERR_MCODE_INDIRECT = 2'h3
	} msps_err_t;

	typedef struct packed {
		logic              by_word;
		logic [WORD_W-1:0] word;
		logic              has_code;
		logic [CODE_W-1:0] code;
		logic              x_given;
		logic [POS_W-1:0]  x;
		logic              y_given;
		logic [POS_W-1:0]  y;
		logic              i_given;
		logic [POS_W-1:0]  i;
		logic              j_given;
		logic [POS_W-1:0]  j;
		logic              r_given;
		logic [POS_W-1:0]  r;
		logic              f_given;
		logic [SPD_W-1:0]  f;
		logic              k_given;
		logic [K_W-1:0]    k;
		logic              m_given;
		logic [M_W-1:0]    m;
		logic              m_indirect;
	} msps_raw_t;

	typedef struct packed {
		msps_op_t          op;
		msps_err_t         err;
		logic [POS_W-1:0]  x;
		logic [POS_W-1:0]  y;
		logic [POS_W-1:0]  i;
		logic [POS_W-1:0]  j;
		logic [POS_W-1:0]  r;
		logic [SPD_W-1:0]  speed;
		logic [K_W-1:0]    k;
		logic              m_valid;
		logic [M_W-1:0]    m;
	} msps_res_t;

endpackage : msps_pkg

// ### src/msps_resolve_if.sv
`timescale 1ns/10ps
interface msps_resolve_if;
	import msps_pkg::*;
	msps_raw_t        raw;
	logic [POS_W-1:0] base_x;
	logic [POS_W-1:0] base_y;
	logic             incr_mode;
	logic             take;
	msps_res_t        res;
	modport resolver  (input raw, base_x, base_y, incr_mode, take, output res);
	modport sequencer (output raw, base_x, base_y, incr_mode, take, input res);
endinterface : msps_resolve_if
